// [hdl/npa_pkg.sv]
package npa_pkg;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int unsigned BLOCK_COUNT     = 1024;
   localparam int unsigned PAGES_PER_BLOCK = 64;
   localparam int unsigned PAGE_BYTES      = 2112;
   localparam int unsigned PAGE_WORDS_X16  = 1056;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_READ_1     = 8'h00;
   localparam logic [7:0] CMD_READ_2     = 8'h30;
   localparam logic [7:0] CMD_CBREAD_2   = 8'h35;
   localparam logic [7:0] CMD_CREAD_2    = 8'h31;
   localparam logic [7:0] CMD_CREAD_EXIT = 8'h34;
   localparam logic [7:0] CMD_SIG        = 8'h90;
   localparam logic [7:0] CMD_RESET      = 8'hFF;
   localparam logic [7:0] CMD_PROG_1     = 8'h80;
   localparam logic [7:0] CMD_CBPROG_1   = 8'h85;
   localparam logic [7:0] CMD_PROG_2     = 8'h10;
   localparam logic [7:0] CMD_CPROG_2    = 8'h15;
   localparam logic [7:0] CMD_ERASE_1    = 8'h60;
   localparam logic [7:0] CMD_ERASE_2    = 8'hD0;
   localparam logic [7:0] CMD_STATUS     = 8'h70;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS   = 8000;
   localparam int unsigned CYCLE_MIN_NS    = 50;
   // strobe low and high halves, each rounded up
   localparam int unsigned HALF_CYC        =
      ((CYCLE_MIN_NS * 1000 / 2) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned LOAD_MAX_US     = 25;
   localparam int unsigned LOAD_MAX_CYC    = LOAD_MAX_US * 1000000 / CLK_PERIOD_PS;
   localparam int unsigned PROG_TYP_US     = 200;
   localparam int unsigned ERASE_TYP_US    = 2000;
   localparam int unsigned BUSY_LAT_CYC    = 4;
   localparam int unsigned FIFO_DEPTH      = 4;

   // ---------------------------------------------------------------
   // operations requested by the user side
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ    = 4'h0,
      OP_PROGRAM = 4'h1,
      OP_ERASE   = 4'h2,
      OP_SIG     = 4'h3,
      OP_RESET   = 4'h4,
      OP_STATUS  = 4'h5,
      OP_CBREAD  = 4'h6,
      OP_CBPROG  = 4'h7,
      OP_CPROG   = 4'h8,
      OP_CREAD   = 4'h9,
      OP_CREXIT  = 4'hA
   } npa_op_e;

   typedef struct packed {
      npa_op_e     op;
      logic [15:0] row;
      logic [11:0] col;
      logic [11:0] count;
   } npa_req_s;

   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] doe;
   } npa_io_s;

   // column and row bytes, unused bit positions held low
   function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [11:0] col,
                                            input logic [15:0] row);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         2'd0: b = col[7:0];
         2'd1: b = {4'h0, col[11:8]};
         2'd2: b = row[7:0];
         default: b = row[15:8];
      endcase
      return b;
   endfunction

endpackage

// [hdl/npa_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module npa_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // drain side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   // honest flags from the occupancy count
   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rp_r];

   // ---------------------------------------------------------------
   // storage and pointers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // npa_fifo
`default_nettype wire

// [hdl/npa_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one shared I/O bus carries command, address and data in time
// - host qualifies every input cycle with select, write strobe, ALE, CLE
// - open-drain ready/busy, wired lines read as global busy
// - page load at most 25us, sequential reads no faster than 50ns
// - x16 carries data on upper lines, command and address low only
// - write-strobe rise latches command when CLE, address when ALE
// - address as four bytes, column first, unused bits low; erase sends two row bytes only, signature one byte
module npa_host
   import npa_pkg::*;
(
   // clock and reset
   input  wire logic                REF_CLK_I,
   input  wire logic                RST_N_I,
   // user request
   input  wire logic                REQ_VALID_I,
   input  wire npa_pkg::npa_req_s   REQ_I,
   output logic                     REQ_READY_O,
   output logic                     DONE_O,
   // user write data
   input  wire logic                WR_VALID_I,
   input  wire logic [15:0]         WR_DATA_I,
   output logic                     WR_READY_O,
   // user read data
   output logic                     RD_VALID_O,
   output logic [15:0]              RD_DATA_O,
   // configuration
   input  wire logic                WIDE_I,
   input  wire logic                UNLOCK_I,
   // memory pins
   output logic                     CHIP_SEL_N_O,
   output logic                     CLE_O,
   output logic                     ALE_O,
   output logic                     WRITE_STROBE_N_O,
   output logic                     READ_STROBE_N_O,
   output logic                     MODIFY_LOCK_N_O,
   input  wire logic                READY_BUSY_I,
   input  wire logic [7:0]          IO_BUS_LOW_I,
   input  wire logic [7:0]          IO_BUS_HIGH_I,
   output npa_pkg::npa_io_s         IO_O
);
   import npa_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_CMD1  = 4'h1,
      ST_ADDR  = 4'h2,
      ST_WDATA = 4'h3,
      ST_CMD2  = 4'h4,
      ST_BUSY  = 4'h5,
      ST_RDATA = 4'h6,
      ST_DONE  = 4'h7
   } npa_st_e;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   npa_st_e     st_r, st_nxt;
   npa_req_s    req_r;
   logic [1:0]  phase_r;        // 0 setup/low, 1 high, then back to 0 for the next cycle
   logic [7:0]  tcnt_r;
   logic [1:0]  acnt_r;
   logic [11:0] dcnt_r;
   logic [3:0]  blat_r;

   // operation decode
   wire is_rd    = (req_r.op == OP_READ) || (req_r.op == OP_CBREAD) || (req_r.op == OP_CREAD);
   wire is_wr    = (req_r.op == OP_PROGRAM) || (req_r.op == OP_CPROG);
   wire is_erase = (req_r.op == OP_ERASE);
   wire has_addr = (req_r.op != OP_RESET) && (req_r.op != OP_STATUS) &&
                   (req_r.op != OP_CREXIT);
   wire has_cmd2 = is_rd || is_wr || is_erase || (req_r.op == OP_CBPROG);
   wire reads_data = is_rd || (req_r.op == OP_SIG) || (req_r.op == OP_STATUS) ||
                     (req_r.op == OP_CREXIT);
   wire waits_busy = has_cmd2 || (req_r.op == OP_RESET) || (req_r.op == OP_CREXIT);
   wire [1:0] alast = is_erase ? 2'd1 : 2'd3;  // erase sends row bytes only

   wire [7:0] cmd1 = (req_r.op == OP_SIG)    ? CMD_SIG :
                     (req_r.op == OP_RESET)  ? CMD_RESET :
                     (req_r.op == OP_STATUS) ? CMD_STATUS :
                     (req_r.op == OP_CREXIT) ? CMD_CREAD_EXIT :
                     (req_r.op == OP_CBPROG) ? CMD_CBPROG_1 :
                     is_wr ? CMD_PROG_1 :
                     is_erase ? CMD_ERASE_1 : CMD_READ_1;
   wire [7:0] cmd2 = (req_r.op == OP_CBREAD) ? CMD_CBREAD_2 :
                     (req_r.op == OP_CREAD)  ? CMD_CREAD_2 :
                     (req_r.op == OP_CPROG)  ? CMD_CPROG_2 :
                     is_erase ? CMD_ERASE_2 :
                     is_rd ? CMD_READ_2 : CMD_PROG_2;
   wire [1:0] aidx = is_erase ? acnt_r + 2'd2 : acnt_r;
   wire [7:0] abyte = addr_byte(aidx, req_r.col, req_r.row);

   // write-data buffer drained one word per write cycle
   logic        wf_valid;
   logic [15:0] wf_data;
   wire         cyc_end  = (phase_r == 2'd1) && (tcnt_r == 8'(HALF_CYC - 1));
   wire         wf_take  = (st_r == ST_WDATA) && cyc_end;
   wire         wd_stall = (st_r == ST_WDATA) && (phase_r == 2'd0) && !wf_valid;
   wire         busy_line = !READY_BUSY_I;  // wired lines, any low is busy

   npa_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clk_i       (REF_CLK_I),
      .rst_n_i     (RST_N_I),
      .in_valid_i  (WR_VALID_I),
      .in_data_i   (WR_DATA_I),
      .in_ready_o  (WR_READY_O),
      .out_valid_o (wf_valid),
      .out_data_o  (wf_data),
      .out_ready_i (wf_take)
   );

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   wire last_data = (dcnt_r == req_r.count);
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:  if (REQ_VALID_I && REQ_READY_O) st_nxt = ST_CMD1;
         ST_CMD1:  if (cyc_end) st_nxt = has_addr ? ST_ADDR :
                                         waits_busy ? ST_BUSY :   // exit reloads first
                                         reads_data ? ST_RDATA : ST_DONE;
         ST_ADDR:  if (cyc_end && (acnt_r == alast) || cyc_end && req_r.op == OP_SIG)
                      st_nxt = is_wr ? ST_WDATA :
                               (req_r.op == OP_SIG) ? ST_RDATA : ST_CMD2;
         ST_WDATA: if (cyc_end && last_data) st_nxt = ST_CMD2;
         ST_CMD2:  if (cyc_end) st_nxt = ST_BUSY;
         ST_BUSY:  if (blat_r == 4'(BUSY_LAT_CYC) && !busy_line)
                      st_nxt = reads_data ? ST_RDATA : ST_DONE;
         ST_RDATA: if (cyc_end && last_data) st_nxt = ST_DONE;
         ST_DONE:  st_nxt = ST_IDLE;
         default:  st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // request capture; signature is four bytes, status one
   always_ff @(posedge REF_CLK_I) begin
      if (st_r == ST_IDLE && REQ_VALID_I && REQ_READY_O) begin  // none on first edge out of reset
         req_r <= REQ_I;
         if (REQ_I.op == OP_SIG) req_r.count <= 12'h003;
         if (REQ_I.op == OP_STATUS) req_r.count <= 12'h000;
      end
   end

   // strobe cycle timer: low half then high half, each >= 25ns
   wire in_cycle = (st_r == ST_CMD1) || (st_r == ST_ADDR) || (st_r == ST_CMD2) ||
                   (st_r == ST_WDATA && !wd_stall) || (st_r == ST_RDATA);
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I || !in_cycle) begin
         phase_r <= 2'd0;
         tcnt_r  <= 8'h00;
      end else if (tcnt_r == 8'(HALF_CYC - 1)) begin
         tcnt_r  <= 8'h00;
         phase_r <= (phase_r == 2'd0) ? 2'd1 : 2'd0;
      end else begin
         tcnt_r <= tcnt_r + 8'h01;
      end
   end

   // address byte and data word counters
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I || st_r == ST_IDLE) begin
         acnt_r <= 2'd0;
         dcnt_r <= 12'h000;
         blat_r <= 4'h0;
      end else begin
         if (st_r == ST_ADDR && cyc_end) acnt_r <= acnt_r + 2'd1;
         if ((st_r == ST_WDATA || st_r == ST_RDATA) && cyc_end) dcnt_r <= dcnt_r + 12'h001;
         if (st_r != ST_BUSY) blat_r <= 4'h0;
         else if (blat_r != 4'(BUSY_LAT_CYC)) blat_r <= blat_r + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // pin drive, all registered
   // ---------------------------------------------------------------
   wire low_half  = in_cycle && (phase_r == 2'd0);
   wire is_wcyc   = (st_r == ST_CMD1) || (st_r == ST_ADDR) || (st_r == ST_CMD2) ||
                    (st_r == ST_WDATA);
   wire [15:0] wval = (st_r == ST_CMD1) ? {8'h00, cmd1} :
                      (st_r == ST_CMD2) ? {8'h00, cmd2} :
                      (st_r == ST_ADDR) ? {8'h00, abyte} :
                      (WIDE_I ? wf_data : {8'h00, wf_data[7:0]});
   wire [15:0] wen  = (st_r == ST_WDATA && WIDE_I) ? 16'hFFFF : 16'h00FF;
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         CHIP_SEL_N_O     <= 1'b1;
         CLE_O            <= 1'b0;
         ALE_O            <= 1'b0;
         WRITE_STROBE_N_O <= 1'b1;
         READ_STROBE_N_O  <= 1'b1;
         MODIFY_LOCK_N_O  <= 1'b0;
         IO_O             <= '0;
      end else begin
         CHIP_SEL_N_O     <= (st_r == ST_IDLE) || (st_r == ST_DONE);
         CLE_O            <= (st_r == ST_CMD1) || (st_r == ST_CMD2);
         ALE_O            <= (st_r == ST_ADDR);
         WRITE_STROBE_N_O <= !(is_wcyc && low_half);   // rise latches the bus
         READ_STROBE_N_O  <= !((st_r == ST_RDATA) && low_half);
         MODIFY_LOCK_N_O  <= UNLOCK_I;                 // low blocks modify
         IO_O.dout        <= is_wcyc ? wval : 16'h0000;
         IO_O.doe         <= is_wcyc ? wen : 16'h0000; // released for reads
      end
   end

   // user handshakes; read word sampled just before strobe rises
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         REQ_READY_O <= 1'b0;
         DONE_O      <= 1'b0;
         RD_VALID_O  <= 1'b0;
         RD_DATA_O   <= 16'h0000;
      end else begin
         REQ_READY_O <= (st_nxt == ST_IDLE);
         DONE_O      <= (st_r == ST_DONE);
         RD_VALID_O  <= (st_r == ST_RDATA) && (phase_r == 2'd0) &&
                        (tcnt_r == 8'(HALF_CYC - 1));
         RD_DATA_O   <= WIDE_I ? {IO_BUS_HIGH_I, IO_BUS_LOW_I} : {8'h00, IO_BUS_LOW_I};
      end
   end
endmodule // npa_host
`default_nettype wire

// [verification/npa_host_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module npa_host_chk
   import npa_pkg::*;
(
   // clock and reset
   input wire logic              REF_CLK_I,
   input wire logic              RST_N_I,
   // memory pins
   input wire logic              CHIP_SEL_N_O,
   input wire logic              CLE_O,
   input wire logic              ALE_O,
   input wire logic              WRITE_STROBE_N_O,
   input wire logic              READ_STROBE_N_O,
   input wire logic              READY_BUSY_I,
   input wire npa_pkg::npa_io_s  IO_O,
   // user status
   input wire logic              DONE_O,
   input wire logic              RD_VALID_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // ---------------------------------------------------------------
   // pin relations
   // ---------------------------------------------------------------
   cle_ale_excl_a: assert property (!(CLE_O && ALE_O))
      else $error("command and address qualifiers both high");
   strobe_excl_a: assert property (!(!WRITE_STROBE_N_O && !READ_STROBE_N_O))
      else $error("both strobes low");
   sel_on_strobe_a: assert property (!WRITE_STROBE_N_O || !READ_STROBE_N_O |-> !CHIP_SEL_N_O)
      else $error("strobe without select");
   bus_release_a: assert property (!READ_STROBE_N_O |-> IO_O.doe == 16'h0000)
      else $error("host drives bus during read");
   hold_latch_a: assert property (!WRITE_STROBE_N_O && !$past(WRITE_STROBE_N_O)
      |-> $stable(CLE_O) && $stable(ALE_O) && $stable(IO_O.dout))
      else $error("qualifier or data moved under write strobe");
   ctl_low_lines_a: assert property (!WRITE_STROBE_N_O && (CLE_O || ALE_O)
      |-> IO_O.dout[15:8] == 8'h00 && IO_O.doe[7:0] == 8'hFF)
      else $error("command or address upper lines not low");
   // ---------------------------------------------------------------
   // strobe cycle shape, 4 low then 4 high
   // ---------------------------------------------------------------
   wr_cycle_a: assert property ($fell(WRITE_STROBE_N_O)
      |-> (!WRITE_STROBE_N_O)[*4] ##1 WRITE_STROBE_N_O[*4])
      else $error("write strobe cycle too short");
   rd_cycle_a: assert property ($fell(READ_STROBE_N_O)
      |-> (!READ_STROBE_N_O)[*4] ##1 READ_STROBE_N_O[*4])
      else $error("read strobe cycle too short");
   busy_cmd_a: assert property ($fell(WRITE_STROBE_N_O) && CLE_O && !READY_BUSY_I
      |-> IO_O.dout[7:0] inside {8'h70, 8'hFF})
      else $error("command issued while busy");
   // main scenarios
   cover property (DONE_O);
   cover property (RD_VALID_O);
   cover property ($fell(READY_BUSY_I));
endmodule // npa_host_chk
bind npa_host npa_host_chk npa_host_chk_inst (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
   .CHIP_SEL_N_O(CHIP_SEL_N_O), .CLE_O(CLE_O), .ALE_O(ALE_O),
   .WRITE_STROBE_N_O(WRITE_STROBE_N_O), .READ_STROBE_N_O(READ_STROBE_N_O),
   .READY_BUSY_I(READY_BUSY_I), .IO_O(IO_O), .DONE_O(DONE_O), .RD_VALID_O(RD_VALID_O));
`default_nettype wire

// [verification/npa_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module npa_dev_model
   import npa_pkg::*;
#(
   parameter logic [31:0] SIG_WORD = 32'h1234_5678, // arbitrary identity value
   parameter int unsigned BUSY_NS  = 400
) (
   // host pins
   input wire logic        clk_i,
   input wire logic        wide_i,
   input wire logic        sel_n_i,
   input wire logic        cle_i,
   input wire logic        ale_i,
   input wire logic        wr_n_i,
   input wire logic        rd_n_i,
   input wire logic        lock_n_i,
   input wire logic [15:0] bus_i,
   // device outputs
   output logic            rb_o = 1'b1,
   output logic [15:0]     io_o
);
   logic [15:0] mem [256] = '{default: 16'hFFFF}; // reduced array, 16 rows of 16 words
   logic [15:0] pg [16];
   logic [7:0]  adr [4];
   logic [15:0] outw = 16'h0000, lastw = 16'h0000, row = 16'h0000;
   logic [11:0] ptr = 12'h000;
   logic [1:0]  mode = 2'd0;
   logic        fail = 1'b0;
   int          acnt = 0, sidx = 0;
   realtime     busy_until = 0;
   // busy runs on its own, no host help needed
   task automatic go_busy();
      busy_until = $realtime + BUSY_NS;
   endtask
   task automatic cmd(input logic [7:0] c);
      case (c)
         8'h00, 8'h60, 8'h80, 8'h85: begin
            acnt = 0;
            mode = 2'd0;
            if (c == 8'h80) pg = '{default: 16'hFFFF}; // 85h keeps the page
         end
         8'h30, 8'h31, 8'h35: begin
            foreach (pg[i]) pg[i] = mem[{row[3:0], 4'(i)}];
            go_busy();
         end
         8'h10, 8'h15, 8'hD0: begin
            fail = !lock_n_i;
            foreach (pg[i]) if (lock_n_i) mem[{(c == 8'hD0) ? adr[0][3:0] : row[3:0], 4'(i)}]
               = (c == 8'hD0) ? 16'hFFFF : pg[i];
            go_busy();
         end
         8'h90: sidx = 0;
         8'h70: mode = 2'd2;
         default: go_busy();
      endcase
      if (c == 8'h90) mode = 2'd1;
   endtask
   // ready line follows the busy window one clock late
   always @(posedge clk_i) rb_o <= ($realtime >= busy_until);
   // write strobe rise latches by qualifier; busy takes only reset and status
   always @(posedge wr_n_i) begin
      if (!sel_n_i && cle_i && (rb_o || bus_i[7:0] inside {8'h70, 8'hFF})) begin
         cmd(bus_i[7:0]);
      end else if (!sel_n_i && ale_i) begin
         adr[acnt[1:0]] = bus_i[7:0];
         acnt++;
         ptr = {adr[1][3:0], adr[0]};
         row = {adr[3], adr[2]};
      end else if (!sel_n_i && !cle_i) begin
         pg[ptr[3:0]] = wide_i ? bus_i : {8'hFF, bus_i[7:0]};
         ptr++;
      end
   end
   // read strobe fall presents the next word only when selected; deselect releases the bus mid-read
   always @(negedge rd_n_i) begin
      if (!sel_n_i && mode == 2'd1) begin
         outw = {8'h00, SIG_WORD[31-8*sidx -: 8]};
         sidx++;
      end else if (!sel_n_i && mode == 2'd2) begin
         outw = {8'h00, lock_n_i, rb_o, 5'b00000, fail};
      end else if (!sel_n_i) begin
         outw = pg[ptr[3:0]];
         ptr++;
      end
   end
   always @(posedge rd_n_i) lastw = outw;
   // no pull-up: a released bus shows a stale inverted value
   assign io_o = (!sel_n_i && !rd_n_i) ? outw : ~lastw;
endmodule // npa_dev_model
`default_nettype wire

// [verification/npa_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module npa_host_tb_top;
   import npa_pkg::*;
   localparam logic [31:0] SIG_WORD = 32'h1234_5678; // arbitrary identity value
   localparam logic [15:0] D [4] = '{16'hA51C, 16'h3C96, 16'h0FF0, 16'h5AA5};
   typedef struct {
      npa_op_e op; logic [15:0] row; logic [11:0] col, cnt; logic wide; int n; logic [15:0] e [4];
   } npa_row_s;
   logic        clk, rst_n = 1'b0, req_valid = 1'b0, wr_valid = 1'b0, wide = 1'b0, unlock = 1'b1;
   logic        req_ready, done, wr_ready, rd_valid, sel_n, cle, ale, wr_n, rd_n, lock_n, rb;
   logic [15:0] wr_data = 16'h0000, rd_data, dev_io, bus;
   npa_req_s    req = '0;
   npa_io_s     io_o;
   npa_row_s    rows [14];
   logic [15:0] got [$];
   int          bad_count = 0, n_compared = 0;
   // host drives where enabled, device elsewhere
   assign bus = (io_o.doe & io_o.dout) | (~io_o.doe & dev_io);
   npa_host npa_host_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid),
      .REQ_I(req), .REQ_READY_O(req_ready), .DONE_O(done), .WR_VALID_I(wr_valid),
      .WR_DATA_I(wr_data), .WR_READY_O(wr_ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
      .WIDE_I(wide), .UNLOCK_I(unlock), .CHIP_SEL_N_O(sel_n), .CLE_O(cle), .ALE_O(ale),
      .WRITE_STROBE_N_O(wr_n), .READ_STROBE_N_O(rd_n), .MODIFY_LOCK_N_O(lock_n),
      .READY_BUSY_I(rb), .IO_BUS_LOW_I(bus[7:0]), .IO_BUS_HIGH_I(bus[15:8]), .IO_O(io_o));
   npa_dev_model #(.SIG_WORD(SIG_WORD)) npa_dev_model_inst (.clk_i(clk), .wide_i(wide),
      .sel_n_i(sel_n), .cle_i(cle), .ale_i(ale), .wr_n_i(wr_n), .rd_n_i(rd_n),
      .lock_n_i(lock_n), .bus_i(bus), .rb_o(rb), .io_o(dev_io));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic summarize();
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic timeout();
      bad_count++;
      $display("[FAIL] %0t handshake wait ran out", $time);
      summarize();
   endtask
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
      end
   endtask
   // fill the buffer, valid held across words
   task automatic push_words();
      wr_valid = 1'b1;
      for (int w = 0; w < 4; w++) begin
         wr_data = D[w];
         for (int k = 0; k < 50 && !wr_ready; k++) @(posedge clk) #1;
         if (!wr_ready) timeout();
         @(posedge clk) #1;
      end
      wr_valid = 1'b0;
   endtask
   // one request, collect read words until done
   task automatic run(input npa_op_e op, input logic [15:0] row, input logic [11:0] col, cnt);
      got.delete();
      req = '{op, row, col, cnt};
      req_valid = 1'b1;
      for (int k = 0; k < 50 && !req_ready; k++) @(posedge clk) #1;
      if (!req_ready) timeout();
      @(posedge clk) #1;
      req_valid = 1'b0;
      for (int k = 0; k < 20000 && !done; k++) begin
         if (rd_valid) got.push_back(rd_data);
         @(posedge clk) #1;
      end
      if (!done) timeout();
      if (rd_valid) got.push_back(rd_data);
   endtask
   initial begin
      rows[0] = '{OP_SIG, 0, 0, 0, 0, 4, '{{8'h00, SIG_WORD[31:24]}, {8'h00, SIG_WORD[23:16]},
                  {8'h00, SIG_WORD[15:8]}, {8'h00, SIG_WORD[7:0]}}};
      rows[1] = '{OP_STATUS, 0, 0, 0, 0, 1, '{16'h00C0, 0, 0, 0}};
      rows[2] = '{OP_ERASE, 5, 0, 0, 1, 0, '{0, 0, 0, 0}};
      rows[3] = '{OP_PROGRAM, 5, 0, 3, 1, 0, '{0, 0, 0, 0}};
      rows[4] = '{OP_READ, 5, 0, 3, 1, 4, D};
      rows[5] = '{OP_READ, 5, 1, 1, 0, 2, '{16'h0096, 16'h00F0, 0, 0}};
      rows[6] = '{OP_CBREAD, 5, 0, 0, 1, 1, '{D[0], 0, 0, 0}};
      rows[7] = '{OP_CBPROG, 6, 0, 0, 1, 0, '{0, 0, 0, 0}};
      rows[8] = '{OP_READ, 6, 1, 0, 1, 1, '{D[1], 0, 0, 0}};
      rows[9] = '{OP_CPROG, 7, 0, 3, 1, 0, '{0, 0, 0, 0}};
      rows[10] = '{OP_READ, 7, 0, 3, 1, 4, D};
      rows[11] = '{OP_CREAD, 5, 0, 1, 1, 2, '{D[0], D[1], 0, 0}};
      rows[12] = '{OP_CREXIT, 0, 0, 0, 1, 1, '{D[2], 0, 0, 0}};
      rows[13] = '{OP_RESET, 0, 0, 0, 1, 0, '{0, 0, 0, 0}};
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (rows[r]) begin
         wide = rows[r].wide;
         if (rows[r].op == OP_PROGRAM || rows[r].op == OP_CPROG) begin
            push_words();
            check({15'h0, wr_ready}, 16'h0000, "full buffer still ready");
         end
         run(rows[r].op, rows[r].row, rows[r].col, rows[r].cnt);
         check(16'(got.size()), 16'(rows[r].n), "word count");
         for (int k = 0; k < rows[r].n; k++) check(got[k], rows[r].e[k], "read word");
      end
      // locked erase refused, page kept, then unlocked erase clears it
      unlock = 1'b0;
      run(OP_ERASE, 5, 0, 0);
      run(OP_STATUS, 0, 0, 0);
      check(got[0], 16'h0041, "locked status");
      unlock = 1'b1;
      run(OP_READ, 5, 3, 0);
      check(got[0], D[3], "page after locked erase");
      run(OP_ERASE, 5, 0, 0);
      run(OP_READ, 5, 2, 0);
      check(got[0], 16'hFFFF, "page after erase");
      // reset between requests leaves pins idle
      rst_n = 1'b0;
      repeat (2) @(posedge clk) #1;
      check({9'h000, sel_n, wr_n, rd_n, cle, ale, lock_n, req_ready}, 16'h0070, "pins in reset");
      rst_n = 1'b1;
      repeat (2) @(posedge clk) #1;
      check({15'h0, req_ready}, 16'h0001, "ready after reset");
      run(OP_STATUS, 0, 0, 0);
      check(got[0], 16'h00C0, "status after reset");
      summarize();
   end
endmodule // npa_host_tb_top
`default_nettype wire
